/* File: core/sse_pkg.sv */
// Shared constants and types for the safing SPI monitor engine.
package sse_pkg;
	localparam int SSE_NUM_REC = 16;
	localparam int SSE_NUM_CS = 5;
	localparam int SSE_NUM_ARM = 4;
	localparam int SSE_NUM_COMB = 12;
	localparam int SSE_WORD_W = 32;
	localparam int SSE_HALF_W = 16;
	localparam int SSE_LEN_W = 6;
	localparam int SSE_TZ_W = 6;
	localparam int SSE_CS_SEL_W = 3;
	localparam int SSE_ARM_SEL_W = 2;
	localparam int SSE_IDX_W = 4;
	localparam int SSE_EVT_W = 8;
	localparam int SSE_DWELL_W = 16;
	localparam logic [SSE_LEN_W-1:0] SSE_LEN_MAX = 6'h3F;
	localparam logic [SSE_LEN_W-1:0] SSE_LEN_ONE = 6'h01;
	localparam logic [SSE_LEN_W-1:0] SSE_LONG_FRAME = 6'h20;
	localparam logic [SSE_TZ_W-1:0] SSE_TZ_ZERO = 6'h00;
	localparam logic [SSE_WORD_W-1:0] SSE_WORD_ONE = 32'h00000001;
	localparam logic [SSE_HALF_W-1:0] SSE_HALF_ZERO = 16'h0000;
	localparam logic signed [SSE_WORD_W-1:0] SSE_RANGE_LIM_8 = 32'sh0000007F;
	localparam logic signed [SSE_WORD_W-1:0] SSE_RANGE_LIM_10 = 32'sh000001FF;
	typedef enum logic [1:0] {SSE_FR_IDLE, SSE_FR_BUSY, SSE_FR_EVAL} sse_frame_type;
endpackage

/* File: core/sse_monitor.sv */
// Safing engine that snoops the remote-sensor SPI bus and drives four internal arming signals.
`timescale 1ns/1ps
`default_nettype none

module sse_monitor
	import sse_pkg::*;
#(
	parameter int EVT_W = SSE_EVT_W,
	parameter int DWELL_W = SSE_DWELL_W
)
(
	input wire logic REF_CLK, // System clock.
	input wire logic SYS_RST, // Synchronous reset, active high.
	input wire logic SPI_SCLK, // Monitored SPI clock, link domain.
	input wire logic SPI_REQUEST_LINE, // Host-to-sensor data, observed.
	input wire logic SENSOR_BUS_RETURN_LINE, // Sensor-to-host data, observed.
	input wire logic SENSOR_BUS_CHIP_SELECT_N, // Main sensor select, active low.
	input wire logic [SSE_NUM_CS-2:0] EXTRA_MONITORED_CHIP_SELECT_N, // Extra selects, active low.
	input wire logic STATE_INIT, // System is in Init state.
	input wire logic STATE_DIAG, // System is in Diag state.
	input wire logic STATE_SAFING, // System is in Safing state.
	input wire logic SAFING_STATE_MACHINE_RESET, // Clears all records.
	input wire logic SENSOR_SYNC_PULSE, // Sensor sync, one-cycle pulse.
	input wire logic [SSE_NUM_REC-1:0] RECORD_ENABLE, // Requested record enables.
	input wire logic CFG_WRITE, // Record settings write strobe.
	input wire logic [SSE_IDX_W-1:0] CFG_INDEX, // Record being written.
	input wire logic [SSE_WORD_W-1:0] CFG_REQUEST_MASK, // Request mask.
	input wire logic [SSE_WORD_W-1:0] CFG_REQUEST_TARGET, // Request target.
	input wire logic [SSE_WORD_W-1:0] CFG_RESPONSE_MASK, // Response mask.
	input wire logic [SSE_WORD_W-1:0] CFG_RESPONSE_TARGET, // Response target.
	input wire logic [SSE_WORD_W-1:0] CFG_RECORD_DATA_MASK, // Contiguous data mask.
	input wire logic [SSE_WORD_W-1:0] CFG_RECORD_THRESHOLD, // Signed threshold magnitude.
	input wire logic [EVT_W-1:0] CFG_ARM_COUNT, // Counter level that arms.
	input wire logic [EVT_W-1:0] CFG_EVENT_INCREMENT, // Counter step on event.
	input wire logic [EVT_W-1:0] CFG_EVENT_DECREMENT, // Counter step without event.
	input wire logic [DWELL_W-1:0] CFG_DWELL, // Dwell in system clock cycles.
	input wire logic CFG_IN_FRAME, // Response in the same frame.
	input wire logic [SSE_CS_SEL_W-1:0] CFG_CS_SELECT, // Select index 0..4.
	input wire logic [SSE_ARM_SEL_W-1:0] CFG_ARM_SELECT, // Arming signal 0..3.
	input wire logic CFG_COMBINE, // Combine with pair partner.
	input wire logic CFG_WIDE, // 32-bit record when set.
	input wire logic CFG_RANGE_CHECK_ENABLE, // Enable out-of-range rejection.
	input wire logic CFG_RANGE_THRESHOLD_SELECT, // 1 selects 10-bit limits.
	input wire logic CFG_LONG_FRAME_FIELD_SELECT, // 1 selects upper half.
	input wire logic ENGINE_SELECT_WRITE, // Engine choice write strobe.
	input wire logic EXTERNAL_ENGINE_SELECT, // 1 selects external engine.
	input wire logic COMPARE_COMPLETE_READ, // Flags read, one-cycle pulse.
	output logic [SSE_NUM_REC-1:0] COMPARE_COMPLETE_FLAGS_REG, // Completion flags.
	output logic INTERNAL_ARM_SIGNAL_1, // Arming signal 1.
	output logic INTERNAL_ARM_SIGNAL_2, // Arming signal 2.
	output logic INTERNAL_ARM_SIGNAL_3, // Arming signal 3.
	output logic INTERNAL_ARM_SIGNAL_4, // Arming signal 4.
	output logic ENGINE_EXTERNAL, // External engine selected.
	output logic [SSE_NUM_REC-1:0] RECORD_ENABLED // Enables in force.
);

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------
	function automatic logic [SSE_TZ_W-1:0] sse_tz(input logic [SSE_WORD_W-1:0] mask);
		sse_tz = SSE_TZ_ZERO;
		for (int i = SSE_WORD_W-1; i >= 0; i--)
		begin
			if (mask[i])
				sse_tz = SSE_TZ_W'(i);
		end
	endfunction

	function automatic logic signed [SSE_WORD_W-1:0] sse_justify(input logic [SSE_WORD_W-1:0] word,
		input logic [SSE_WORD_W-1:0] mask, input logic wide);
		logic [SSE_WORD_W-1:0] shifted;
		shifted = (word & mask) >> sse_tz(mask);
		if (wide)
			sse_justify = shifted;
		else
			sse_justify = {{SSE_HALF_W{shifted[SSE_HALF_W-1]}}, shifted[SSE_HALF_W-1:0]};
	endfunction

	function automatic logic [SSE_WORD_W-1:0] sse_len_mask(input logic [SSE_LEN_W-1:0] len);
		if (len >= SSE_LONG_FRAME)
			sse_len_mask = '1;
		else
			sse_len_mask = (SSE_WORD_ONE << len) - SSE_WORD_ONE;
	endfunction

	function automatic logic [EVT_W-1:0] sse_sat_add(input logic [EVT_W-1:0] a, input logic [EVT_W-1:0] b);
		logic [EVT_W:0] s;
		s = {1'b0, a} + {1'b0, b};
		sse_sat_add = s[EVT_W] ? '1 : s[EVT_W-1:0];
	endfunction

	function automatic logic [EVT_W-1:0] sse_sat_sub(input logic [EVT_W-1:0] a, input logic [EVT_W-1:0] b);
		sse_sat_sub = (a > b) ? a - b : '0;
	endfunction

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [SSE_NUM_CS-1:0] cs_pins;
	logic link_idle;
	logic [SSE_LEN_W-1:0] bit_cnt_r;
	logic [SSE_LEN_W-1:0] bit_len_nxt;
	logic [SSE_LEN_W-1:0] link_len_r;
	logic [SSE_WORD_W-1:0] mosi_sr_r;
	logic [SSE_WORD_W-1:0] miso_sr_r;
	logic [SSE_NUM_CS-1:0] cs_s1_r;
	logic [SSE_NUM_CS-1:0] cs_s2_r;
	logic [SSE_NUM_CS-1:0] cs_s3_r;
	logic [SSE_NUM_CS-1:0] cs_filt_r;
	logic cs_any;
	logic [SSE_CS_SEL_W-1:0] cs_first;
	sse_frame_type fr_state_r;
	logic [SSE_CS_SEL_W-1:0] fr_cs_r;
	logic [SSE_WORD_W-1:0] fr_req_r;
	logic [SSE_WORD_W-1:0] fr_rsp_r;
	logic [SSE_LEN_W-1:0] fr_len_r;
	logic fr_done;
	logic fr_eval;
	logic wipe;
	logic [SSE_WORD_W-1:0] req_mask_r [SSE_NUM_REC];
	logic [SSE_WORD_W-1:0] req_tgt_r [SSE_NUM_REC];
	logic [SSE_WORD_W-1:0] rsp_mask_r [SSE_NUM_REC];
	logic [SSE_WORD_W-1:0] rsp_tgt_r [SSE_NUM_REC];
	logic [SSE_WORD_W-1:0] data_mask_r [SSE_NUM_REC];
	logic signed [SSE_WORD_W-1:0] thr_r [SSE_NUM_REC];
	logic [EVT_W-1:0] arm_cnt_r [SSE_NUM_REC];
	logic [EVT_W-1:0] inc_r [SSE_NUM_REC];
	logic [EVT_W-1:0] dec_r [SSE_NUM_REC];
	logic [DWELL_W-1:0] dwell_cfg_r [SSE_NUM_REC];
	logic [SSE_CS_SEL_W-1:0] cs_sel_r [SSE_NUM_REC];
	logic [SSE_ARM_SEL_W-1:0] arm_sel_r [SSE_NUM_REC];
	logic [SSE_NUM_REC-1:0] in_frame_r;
	logic [SSE_NUM_REC-1:0] comb_r;
	logic [SSE_NUM_REC-1:0] wide_r;
	logic [SSE_NUM_REC-1:0] rng_en_r;
	logic [SSE_NUM_REC-1:0] rng_sel_r;
	logic [SSE_NUM_REC-1:0] fld_sel_r;
	logic [SSE_NUM_REC-1:0] en_act_r;
	logic ext_sel_r;
	logic [SSE_NUM_REC-1:0] cc_r;
	logic [SSE_NUM_REC-1:0] pend_r;
	logic [SSE_NUM_REC-1:0] pend_nxt;
	logic [SSE_NUM_REC-1:0] hit;
	logic signed [SSE_WORD_W-1:0] hit_val [SSE_NUM_REC];
	logic [SSE_NUM_REC-1:0] cap_vld_r;
	logic signed [SSE_WORD_W-1:0] cap_val_r [SSE_NUM_REC];
	logic [SSE_NUM_REC-1:0] done_r;
	logic [SSE_NUM_REC-1:0] eval_go;
	logic [SSE_NUM_REC-1:0] arm_cond;
	logic [EVT_W-1:0] pos_r [SSE_NUM_REC];
	logic [EVT_W-1:0] neg_r [SSE_NUM_REC];
	logic [EVT_W-1:0] pos_nxt [SSE_NUM_REC];
	logic [EVT_W-1:0] neg_nxt [SSE_NUM_REC];
	logic [DWELL_W-1:0] dwell_r [SSE_NUM_REC];
	logic [SSE_NUM_ARM-1:0] arm_r;

	assign cs_pins = {EXTRA_MONITORED_CHIP_SELECT_N, SENSOR_BUS_CHIP_SELECT_N};
	assign wipe = SYS_RST | SAFING_STATE_MACHINE_RESET;

	// ----------------------------------------------------------------
	// Link domain capture
	// ----------------------------------------------------------------
	// The SPI clock only runs inside frames, so the bit count is cleared by the
	// idle selects themselves rather than by an edge that may never come.
	assign link_idle = &cs_pins;
	assign bit_len_nxt = (bit_cnt_r == SSE_LEN_MAX) ? SSE_LEN_MAX : bit_cnt_r + SSE_LEN_ONE;

	always_ff @(posedge SPI_SCLK or posedge link_idle)
	begin
		if (link_idle)
			bit_cnt_r <= '0;
		else
			bit_cnt_r <= bit_len_nxt;
	end

	// Both lines are inputs only; the engine never drives the bus.
	always_ff @(posedge SPI_SCLK)
	begin
		mosi_sr_r <= {mosi_sr_r[SSE_WORD_W-2:0], SPI_REQUEST_LINE};
		miso_sr_r <= {miso_sr_r[SSE_WORD_W-2:0], SENSOR_BUS_RETURN_LINE};
		link_len_r <= bit_len_nxt;
	end

	// ----------------------------------------------------------------
	// Select synchronisers and frame tracking
	// ----------------------------------------------------------------
	always_ff @(posedge REF_CLK)
	begin
		if (SYS_RST)
		begin
			cs_s1_r <= '1;
			cs_s2_r <= '1;
			cs_s3_r <= '1;
		end
		else
		begin
			cs_s1_r <= cs_pins;
			cs_s2_r <= cs_s1_r;
			cs_s3_r <= cs_s2_r;
		end
	end

	always_ff @(posedge REF_CLK)
	begin
		if (SYS_RST)
			cs_filt_r <= '1;
		else
			for (int i = 0; i < SSE_NUM_CS; i++)
				if (cs_s2_r[i] == cs_s3_r[i])
					cs_filt_r[i] <= cs_s3_r[i];
	end

	always_comb
	begin
		cs_any = 1'b0;
		cs_first = '0;
		for (int i = SSE_NUM_CS-1; i >= 0; i--)
		begin
			if (!cs_filt_r[i])
			begin
				cs_any = 1'b1;
				cs_first = SSE_CS_SEL_W'(i);
			end
		end
	end

	assign fr_done = (fr_state_r == SSE_FR_BUSY) && cs_filt_r[fr_cs_r];
	assign fr_eval = (fr_state_r == SSE_FR_EVAL);

	always_ff @(posedge REF_CLK)
	begin
		if (SYS_RST)
		begin
			fr_state_r <= SSE_FR_IDLE;
			fr_cs_r <= '0;
		end
		else
			unique case (fr_state_r)
				SSE_FR_IDLE:
					if (cs_any)
					begin
						fr_state_r <= SSE_FR_BUSY;
						fr_cs_r <= cs_first;
					end
				SSE_FR_BUSY:
					if (fr_done)
						fr_state_r <= SSE_FR_EVAL;
				SSE_FR_EVAL:
					fr_state_r <= SSE_FR_IDLE;
				default:
					fr_state_r <= SSE_FR_IDLE;
			endcase
	end

	// The link registers are quiet once the select has closed, and three
	// synchroniser stages and the filter stage later they are read here; the inter-frame gap keeps
	// them stable until this copy is taken.
	always_ff @(posedge REF_CLK)
	begin
		if (SYS_RST)
		begin
			fr_req_r <= '0;
			fr_rsp_r <= '0;
			fr_len_r <= '0;
		end
		else if (fr_done)
		begin
			fr_req_r <= mosi_sr_r & sse_len_mask(link_len_r);
			fr_rsp_r <= miso_sr_r & sse_len_mask(link_len_r);
			fr_len_r <= link_len_r;
		end
	end

	// ----------------------------------------------------------------
	// Record settings and global engine choice
	// ----------------------------------------------------------------
	always_ff @(posedge REF_CLK)
	begin
		if (wipe)
		begin
			for (int r = 0; r < SSE_NUM_REC; r++)
			begin
				req_mask_r[r] <= '0;
				req_tgt_r[r] <= '0;
				rsp_mask_r[r] <= '0;
				rsp_tgt_r[r] <= '0;
				data_mask_r[r] <= '0;
				thr_r[r] <= '0;
				arm_cnt_r[r] <= '0;
				inc_r[r] <= '0;
				dec_r[r] <= '0;
				dwell_cfg_r[r] <= '0;
				cs_sel_r[r] <= '0;
				arm_sel_r[r] <= '0;
			end
			in_frame_r <= '0;
			comb_r <= '0;
			wide_r <= '0;
			rng_en_r <= '0;
			rng_sel_r <= '0;
			fld_sel_r <= '0;
		end
		else if (CFG_WRITE && STATE_DIAG)
		begin
			req_mask_r[CFG_INDEX] <= CFG_REQUEST_MASK;
			req_tgt_r[CFG_INDEX] <= CFG_REQUEST_TARGET;
			rsp_mask_r[CFG_INDEX] <= CFG_RESPONSE_MASK;
			rsp_tgt_r[CFG_INDEX] <= CFG_RESPONSE_TARGET;
			data_mask_r[CFG_INDEX] <= CFG_RECORD_DATA_MASK;
			thr_r[CFG_INDEX] <= CFG_RECORD_THRESHOLD;
			arm_cnt_r[CFG_INDEX] <= CFG_ARM_COUNT;
			inc_r[CFG_INDEX] <= CFG_EVENT_INCREMENT;
			dec_r[CFG_INDEX] <= CFG_EVENT_DECREMENT;
			dwell_cfg_r[CFG_INDEX] <= CFG_DWELL;
			cs_sel_r[CFG_INDEX] <= CFG_CS_SELECT;
			arm_sel_r[CFG_INDEX] <= CFG_ARM_SELECT;
			in_frame_r[CFG_INDEX] <= CFG_IN_FRAME;
			comb_r[CFG_INDEX] <= CFG_COMBINE;
			wide_r[CFG_INDEX] <= CFG_WIDE;
			rng_en_r[CFG_INDEX] <= CFG_RANGE_CHECK_ENABLE;
			rng_sel_r[CFG_INDEX] <= CFG_RANGE_THRESHOLD_SELECT;
			fld_sel_r[CFG_INDEX] <= CFG_LONG_FRAME_FIELD_SELECT;
		end
	end

	// Enables may be written at any time but only take hold on the sync pulse.
	always_ff @(posedge REF_CLK)
	begin
		if (wipe)
			en_act_r <= '0;
		else if (SENSOR_SYNC_PULSE)
			en_act_r <= RECORD_ENABLE;
	end

	always_ff @(posedge REF_CLK)
	begin
		if (SYS_RST)
			ext_sel_r <= 1'b0;
		else if (ENGINE_SELECT_WRITE && STATE_INIT)
			ext_sel_r <= EXTERNAL_ENGINE_SELECT;
	end

	// ----------------------------------------------------------------
	// Frame decoding against every record
	// ----------------------------------------------------------------
	always_comb
	begin
		logic [SSE_WORD_W-1:0] rsp;
		logic signed [SSE_WORD_W-1:0] val;
		logic elig;
		logic req_ok;
		logic rsp_ok;
		logic out_rng;
		rsp = '0;
		val = '0;
		elig = 1'b0;
		req_ok = 1'b0;
		rsp_ok = 1'b0;
		out_rng = 1'b0;
		for (int r = 0; r < SSE_NUM_REC; r++)
		begin
			if (wide_r[r])
				rsp = fr_rsp_r;
			else if (fr_len_r >= SSE_LONG_FRAME && fld_sel_r[r])
				rsp = {SSE_HALF_ZERO, fr_rsp_r[SSE_WORD_W-1:SSE_HALF_W]};
			else
				rsp = {SSE_HALF_ZERO, fr_rsp_r[SSE_HALF_W-1:0]};
			// Upper word of a wide record is the first half shifted in.
			val = sse_justify(rsp, data_mask_r[r], wide_r[r]);
			if (!rng_en_r[r])
				out_rng = 1'b0;
			else if (rng_sel_r[r])
				out_rng = (val > SSE_RANGE_LIM_10) || (val < -SSE_RANGE_LIM_10);
			else
				out_rng = (val > SSE_RANGE_LIM_8) || (val < -SSE_RANGE_LIM_8);
			elig = fr_eval && en_act_r[r] && STATE_SAFING && !ext_sel_r && !cc_r[r]
				&& (cs_sel_r[r] == fr_cs_r);
			req_ok = (fr_req_r & req_mask_r[r]) == req_tgt_r[r];
			rsp_ok = (fr_rsp_r & rsp_mask_r[r]) == rsp_tgt_r[r];
			hit[r] = elig && rsp_ok && !out_rng && (in_frame_r[r] ? req_ok : pend_r[r]);
			hit_val[r] = val;
			if (fr_eval && cs_sel_r[r] == fr_cs_r)
				pend_nxt[r] = elig && !in_frame_r[r] && req_ok;
			else
				pend_nxt[r] = pend_r[r];
		end
	end

	always_ff @(posedge REF_CLK)
	begin
		if (wipe)
			pend_r <= '0;
		else
			pend_r <= pend_nxt;
	end

	// A capture in the same cycle as the read keeps its flag.
	always_ff @(posedge REF_CLK)
	begin
		if (wipe)
			cc_r <= '0;
		else
			cc_r <= hit | (cc_r & ~{SSE_NUM_REC{COMPARE_COMPLETE_READ}});
	end

	always_ff @(posedge REF_CLK)
	begin
		for (int r = 0; r < SSE_NUM_REC; r++)
		begin
			if (wipe)
			begin
				cap_vld_r[r] <= 1'b0;
				cap_val_r[r] <= '0;
				done_r[r] <= 1'b0;
			end
			else if (hit[r])
			begin
				cap_vld_r[r] <= 1'b1;
				cap_val_r[r] <= hit_val[r];
				done_r[r] <= 1'b0;
			end
			else if (COMPARE_COMPLETE_READ)
			begin
				cap_vld_r[r] <= 1'b0;
				done_r[r] <= 1'b0;
			end
			else if (eval_go[r])
				done_r[r] <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Combine, threshold comparison and event counters
	// ----------------------------------------------------------------
	always_comb
	begin
		logic signed [SSE_WORD_W-1:0] v;
		logic comb_eff;
		logic ev_pos;
		logic ev_neg;
		v = '0;
		comb_eff = 1'b0;
		ev_pos = 1'b0;
		ev_neg = 1'b0;
		for (int r = 0; r < SSE_NUM_REC; r++)
		begin
			comb_eff = comb_r[r] && (r < SSE_NUM_COMB) && !wide_r[r] && !wide_r[r ^ 1];
			eval_go[r] = cap_vld_r[r] && !done_r[r] && (!comb_eff || cap_vld_r[r ^ 1]);
			if (!comb_eff)
				v = cap_val_r[r];
			else if ((r % 2) == 0)
				v = cap_val_r[r] + cap_val_r[r + 1];
			else
				v = cap_val_r[r - 1] - cap_val_r[r];
			ev_pos = v > thr_r[r];
			ev_neg = v < -thr_r[r];
			pos_nxt[r] = ev_pos ? sse_sat_add(pos_r[r], inc_r[r]) : sse_sat_sub(pos_r[r], dec_r[r]);
			neg_nxt[r] = ev_neg ? sse_sat_add(neg_r[r], inc_r[r]) : sse_sat_sub(neg_r[r], dec_r[r]);
			arm_cond[r] = (pos_nxt[r] >= arm_cnt_r[r]) || (neg_nxt[r] >= arm_cnt_r[r]);
		end
	end

	always_ff @(posedge REF_CLK)
	begin
		for (int r = 0; r < SSE_NUM_REC; r++)
		begin
			if (wipe)
			begin
				pos_r[r] <= '0;
				neg_r[r] <= '0;
			end
			else if (eval_go[r])
			begin
				pos_r[r] <= pos_nxt[r];
				neg_r[r] <= neg_nxt[r];
			end
		end
	end

	// ----------------------------------------------------------------
	// Dwell stretch and arming outputs
	// ----------------------------------------------------------------
	// Dwell is only ever extended; a zero setting still arms for one cycle.
	always_ff @(posedge REF_CLK)
	begin
		for (int r = 0; r < SSE_NUM_REC; r++)
		begin
			if (wipe)
				dwell_r[r] <= '0;
			else if (eval_go[r] && arm_cond[r] && dwell_r[r] <= dwell_cfg_r[r])
				dwell_r[r] <= (dwell_cfg_r[r] == '0) ? DWELL_W'(1) : dwell_cfg_r[r];
			else if (dwell_r[r] != '0)
				dwell_r[r] <= dwell_r[r] - DWELL_W'(1);
		end
	end

	always_ff @(posedge REF_CLK)
	begin
		if (wipe)
			arm_r <= '0;
		else
			for (int a = 0; a < SSE_NUM_ARM; a++)
			begin
				arm_r[a] <= 1'b0;
				for (int r = 0; r < SSE_NUM_REC; r++)
					if (en_act_r[r] && dwell_r[r] != '0 && arm_sel_r[r] == SSE_ARM_SEL_W'(a))
						arm_r[a] <= 1'b1;
			end
	end

	assign INTERNAL_ARM_SIGNAL_1 = arm_r[0];
	assign INTERNAL_ARM_SIGNAL_2 = arm_r[1];
	assign INTERNAL_ARM_SIGNAL_3 = arm_r[2];
	assign INTERNAL_ARM_SIGNAL_4 = arm_r[3];
	assign COMPARE_COMPLETE_FLAGS_REG = cc_r;
	assign ENGINE_EXTERNAL = ext_sel_r;
	assign RECORD_ENABLED = en_act_r;

endmodule

`default_nettype wire

/* File: verif/sse_monitor_assertions.sv */
// Port-level checks for the safing SPI monitor.
`timescale 1ns/1ps
`default_nettype none

module sse_monitor_assertions
	import sse_pkg::*;
(
	input wire logic REF_CLK, // Clock.
	input wire logic SYS_RST, // Reset.
	input wire logic STATE_INIT, // Init state.
	input wire logic STATE_SAFING, // Safing state.
	input wire logic SAFING_STATE_MACHINE_RESET, // Record clear.
	input wire logic SENSOR_SYNC_PULSE, // Sync pulse.
	input wire logic [SSE_NUM_REC-1:0] RECORD_ENABLE, // Requested enables.
	input wire logic ENGINE_SELECT_WRITE, // Engine write.
	input wire logic EXTERNAL_ENGINE_SELECT, // Engine choice.
	input wire logic COMPARE_COMPLETE_READ, // Flag read.
	input wire logic [SSE_NUM_REC-1:0] COMPARE_COMPLETE_FLAGS_REG, // Flags.
	input wire logic INTERNAL_ARM_SIGNAL_1, // Arm 1.
	input wire logic INTERNAL_ARM_SIGNAL_2, // Arm 2.
	input wire logic INTERNAL_ARM_SIGNAL_3, // Arm 3.
	input wire logic INTERNAL_ARM_SIGNAL_4, // Arm 4.
	input wire logic ENGINE_EXTERNAL, // Engine in force.
	input wire logic [SSE_NUM_REC-1:0] RECORD_ENABLED // Enables in force.
);
	logic [3:0] arm;
	assign arm = {INTERNAL_ARM_SIGNAL_4, INTERNAL_ARM_SIGNAL_3, INTERNAL_ARM_SIGNAL_2, INTERNAL_ARM_SIGNAL_1};
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (SYS_RST);
	// Three idle cycles cover the decode pipeline, so a late state check still counts.
	sequence s_off3;
		(!STATE_SAFING || ENGINE_EXTERNAL)[*3];
	endsequence
	property p_en_hold;
		!SENSOR_SYNC_PULSE && !SAFING_STATE_MACHINE_RESET |=> $stable(RECORD_ENABLED);
	endproperty
	a_en_hold: assert property (p_en_hold) else $error("enables changed without sync");
	property p_en_load;
		SENSOR_SYNC_PULSE && !SAFING_STATE_MACHINE_RESET |=> RECORD_ENABLED == $past(RECORD_ENABLE);
	endproperty
	a_en_load: assert property (p_en_load) else $error("enables not loaded on sync");
	property p_read_clear;
		COMPARE_COMPLETE_READ |=> (COMPARE_COMPLETE_FLAGS_REG & $past(COMPARE_COMPLETE_FLAGS_REG)) == 16'h0000;
	endproperty
	a_read_clear: assert property (p_read_clear) else $error("flags kept after read");
	property p_flag_sticky;
		!COMPARE_COMPLETE_READ && !SAFING_STATE_MACHINE_RESET
			|=> (COMPARE_COMPLETE_FLAGS_REG & $past(COMPARE_COMPLETE_FLAGS_REG)) == $past(COMPARE_COMPLETE_FLAGS_REG);
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped without read");
	property p_no_new_flag;
		s_off3 |=> (COMPARE_COMPLETE_FLAGS_REG & ~$past(COMPARE_COMPLETE_FLAGS_REG)) == 16'h0000;
	endproperty
	a_no_new_flag: assert property (p_no_new_flag) else $error("flag set outside safing");
	property p_ssm_clear;
		SAFING_STATE_MACHINE_RESET |=> COMPARE_COMPLETE_FLAGS_REG == 16'h0000 && arm == 4'h0 && RECORD_ENABLED == 16'h0000;
	endproperty
	a_ssm_clear: assert property (p_ssm_clear) else $error("records not cleared");
	property p_eng_hold;
		!(ENGINE_SELECT_WRITE && STATE_INIT) |=> $stable(ENGINE_EXTERNAL);
	endproperty
	a_eng_hold: assert property (p_eng_hold) else $error("engine choice changed");
	property p_eng_load;
		ENGINE_SELECT_WRITE && STATE_INIT |=> ENGINE_EXTERNAL == $past(EXTERNAL_ENGINE_SELECT);
	endproperty
	a_eng_load: assert property (p_eng_load) else $error("engine choice not stored");
	property p_arm_enabled;
		arm != 4'h0 |-> ($past(RECORD_ENABLED) | RECORD_ENABLED) != 16'h0000;
	endproperty
	a_arm_enabled: assert property (p_arm_enabled) else $error("arm without enabled record");
endmodule

bind sse_monitor sse_monitor_assertions sse_monitor_assertions_inst (.REF_CLK, .SYS_RST, .STATE_INIT,
	.STATE_SAFING, .SAFING_STATE_MACHINE_RESET, .SENSOR_SYNC_PULSE, .RECORD_ENABLE, .ENGINE_SELECT_WRITE,
	.EXTERNAL_ENGINE_SELECT, .COMPARE_COMPLETE_READ, .COMPARE_COMPLETE_FLAGS_REG, .INTERNAL_ARM_SIGNAL_1,
	.INTERNAL_ARM_SIGNAL_2, .INTERNAL_ARM_SIGNAL_3, .INTERNAL_ARM_SIGNAL_4, .ENGINE_EXTERNAL, .RECORD_ENABLED);
`default_nettype wire

/* File: verif/sse_spi_host.sv */
// Behavioural host and sensors on the monitored SPI bus.
`timescale 1ns/1ps
`default_nettype none

module sse_spi_host
(
	output logic sclk, // Link clock, stands low between frames.
	output logic mosi, // Request data.
	output logic miso, // Response data.
	output logic [4:0] cs_n // Selects, active low.
);
	initial
	begin
		sclk = 1'b0;
		mosi = 1'b0;
		miso = 1'b0;
		cs_n = 5'h1F;
	end
	task automatic send(input int cs, input logic [31:0] req, input logic [31:0] rsp);
		int i;
		#43.3;
		cs_n[cs] = 1'b0;
		for (i = 31; i >= 0; i--)
		begin
			mosi = req[i];
			miso = rsp[i];
			#7.5 sclk = 1'b1;
			#7.5 sclk = 1'b0;
		end
		// A full bit after the last sample gives the response time to cross clocks.
		#7.5 cs_n[cs] = 1'b1;
		// Released lines must not keep the last bit, or stale data could pass.
		mosi = ~mosi;
		miso = ~miso;
	endtask
endmodule
`default_nettype wire

/* File: verif/sse_monitor_tb.sv */
// Self-checking bench for the safing SPI monitor.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
	$display("mismatch t=%0t got %h exp %h", $time, g, e); end end

module sse_monitor_tb import sse_pkg::*;;
	logic REF_CLK = 1'b0, SYS_RST = 1'b1, STATE_INIT = 1'b0, STATE_DIAG = 1'b0, STATE_SAFING = 1'b0;
	logic SAFING_STATE_MACHINE_RESET = 1'b0, SENSOR_SYNC_PULSE = 1'b0, CFG_WRITE = 1'b0, CFG_IN_FRAME = 1'b1;
	logic CFG_COMBINE = 1'b0, CFG_WIDE = 1'b0, CFG_RANGE_CHECK_ENABLE = 1'b0, CFG_RANGE_THRESHOLD_SELECT = 1'b0;
	logic CFG_LONG_FRAME_FIELD_SELECT = 1'b0, ENGINE_SELECT_WRITE = 1'b0, EXTERNAL_ENGINE_SELECT = 1'b0;
	logic COMPARE_COMPLETE_READ = 1'b0;
	logic [15:0] RECORD_ENABLE = 16'h0000, CFG_DWELL = 16'h0014, en = 16'h0000;
	logic [3:0] CFG_INDEX = 4'h0;
	logic [31:0] CFG_REQUEST_MASK = 32'hFF000000, CFG_REQUEST_TARGET = 32'h3C000000;
	logic [31:0] CFG_RESPONSE_MASK = 32'hFF000000, CFG_RESPONSE_TARGET = 32'hA5000000;
	logic [31:0] CFG_RECORD_DATA_MASK = 32'h0000FFFF, CFG_RECORD_THRESHOLD = 32'h00000100;
	logic [7:0] CFG_ARM_COUNT = 8'h01, CFG_EVENT_INCREMENT = 8'h01, CFG_EVENT_DECREMENT = 8'h01;
	logic [2:0] CFG_CS_SELECT = 3'h0;
	logic [1:0] CFG_ARM_SELECT = 2'h0;
	logic signed [15:0] d;
	wire logic SPI_SCLK, SPI_REQUEST_LINE, SENSOR_BUS_RETURN_LINE, SENSOR_BUS_CHIP_SELECT_N, ENGINE_EXTERNAL;
	wire logic [3:0] EXTRA_MONITORED_CHIP_SELECT_N, arm;
	wire logic [15:0] COMPARE_COMPLETE_FLAGS_REG, RECORD_ENABLED;
	int n_mismatch = 0, n_compared = 0, seed = 95337, pos = 0, neg = 0, v, i, k, armed;
	int vals[7] = '{256, 257, -256, -257, 0, 32767, -32768};
	localparam int TH = 256;

	always #2 REF_CLK = ~REF_CLK;

	sse_monitor sse_monitor_inst (.REF_CLK, .SYS_RST, .SPI_SCLK, .SPI_REQUEST_LINE, .SENSOR_BUS_RETURN_LINE,
		.SENSOR_BUS_CHIP_SELECT_N, .EXTRA_MONITORED_CHIP_SELECT_N, .STATE_INIT, .STATE_DIAG, .STATE_SAFING,
		.SAFING_STATE_MACHINE_RESET, .SENSOR_SYNC_PULSE, .RECORD_ENABLE, .CFG_WRITE, .CFG_INDEX, .CFG_REQUEST_MASK,
		.CFG_REQUEST_TARGET, .CFG_RESPONSE_MASK, .CFG_RESPONSE_TARGET, .CFG_RECORD_DATA_MASK, .CFG_RECORD_THRESHOLD,
		.CFG_ARM_COUNT, .CFG_EVENT_INCREMENT, .CFG_EVENT_DECREMENT, .CFG_DWELL, .CFG_IN_FRAME, .CFG_CS_SELECT,
		.CFG_ARM_SELECT, .CFG_COMBINE, .CFG_WIDE, .CFG_RANGE_CHECK_ENABLE, .CFG_RANGE_THRESHOLD_SELECT,
		.CFG_LONG_FRAME_FIELD_SELECT, .ENGINE_SELECT_WRITE, .EXTERNAL_ENGINE_SELECT, .COMPARE_COMPLETE_READ,
		.COMPARE_COMPLETE_FLAGS_REG, .INTERNAL_ARM_SIGNAL_1(arm[0]), .INTERNAL_ARM_SIGNAL_2(arm[1]),
		.INTERNAL_ARM_SIGNAL_3(arm[2]), .INTERNAL_ARM_SIGNAL_4(arm[3]), .ENGINE_EXTERNAL, .RECORD_ENABLED);
	sse_spi_host sse_spi_host_inst (.sclk(SPI_SCLK), .mosi(SPI_REQUEST_LINE), .miso(SENSOR_BUS_RETURN_LINE),
		.cs_n({EXTRA_MONITORED_CHIP_SELECT_N, SENSOR_BUS_CHIP_SELECT_N}));

	task final_report;
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task cfg(input int idx, input int cs, input int am, input int inf, input logic [31:0] th);
		@(posedge REF_CLK);
		CFG_WRITE <= 1'b1;
		CFG_INDEX <= idx[3:0];
		CFG_CS_SELECT <= cs[2:0];
		CFG_ARM_SELECT <= am[1:0];
		CFG_IN_FRAME <= inf[0];
		CFG_RECORD_THRESHOLD <= th;
		@(posedge REF_CLK);
		CFG_WRITE <= 1'b0;
	endtask

	task sync_en(input logic [15:0] e);
		@(posedge REF_CLK);
		RECORD_ENABLE <= e;
		SENSOR_SYNC_PULSE <= 1'b1;
		@(posedge REF_CLK);
		SENSOR_SYNC_PULSE <= 1'b0;
		@(negedge REF_CLK);
		`CHK(RECORD_ENABLED, e)
		en = e;
	endtask

	initial
	begin
		repeat (12) @(posedge REF_CLK);
		SYS_RST <= 1'b0;
		@(negedge REF_CLK);
		`CHK({COMPARE_COMPLETE_FLAGS_REG, RECORD_ENABLED, arm, ENGINE_EXTERNAL}, 37'h0000000000)
		for (k = 0; k < 3; k++)
		begin
			@(posedge REF_CLK);
			STATE_INIT <= (k > 0);
			ENGINE_SELECT_WRITE <= 1'b1;
			EXTERNAL_ENGINE_SELECT <= (k < 2);
			@(posedge REF_CLK);
			ENGINE_SELECT_WRITE <= 1'b0;
			@(negedge REF_CLK);
			`CHK(ENGINE_EXTERNAL, k == 1)
		end
		STATE_INIT <= 1'b0;
		STATE_DIAG <= 1'b1;
		$display("test engine select done");
		// Records 0..3 share one setup on four arms; 4 waits on another select; 5 is out of frame.
		for (k = 0; k < 6; k++)
			cfg(k, k == 4, k < 4 ? k : 0, k != 5, k == 5 ? 32'h7FFFFFFF : TH);
		STATE_DIAG <= 1'b0;
		STATE_SAFING <= 1'b1;
		cfg(0, 1, 0, 1, TH);
		RECORD_ENABLE <= 16'h003F;
		repeat (3) @(negedge REF_CLK);
		`CHK(RECORD_ENABLED, 16'h0000)
		sync_en(16'h003F);
		for (k = 0; k < 14; k++)
		begin
			if (k == 9)
				sync_en(16'h0037);
			v = k < 7 ? vals[k] : $random(seed);
			d = v[15:0];
			sse_spi_host_inst.send(0, 32'h3C000000, {k == 0 ? 8'h5A : 8'hA5, 8'h00, d});
			for (i = 0; i < 40 && COMPARE_COMPLETE_FLAGS_REG[0] !== 1'b1; i++)
				@(negedge REF_CLK);
			if (i == 40 && k > 0)
			begin
				n_mismatch++;
				final_report;
			end
			if (k > 0)
			begin
				pos = d > TH ? pos + (pos < 255) : pos - (pos > 0);
				neg = d < -TH ? neg + (neg < 255) : neg - (neg > 0);
			end
			armed = k > 0 && (pos >= 1 || neg >= 1);
			repeat (4) @(negedge REF_CLK);
			// The frame ignored at k 8 leaves record 5 unpaired at k 9.
			`CHK(COMPARE_COMPLETE_FLAGS_REG, k > 0 ? en & (k == 9 ? 16'h000F : 16'h002F) : 16'h0000)
			`CHK(arm, armed ? en[3:0] : 4'h0)
			repeat (14) @(negedge REF_CLK);
			`CHK(arm, armed ? en[3:0] : 4'h0)
			repeat (8) @(negedge REF_CLK);
			`CHK(arm, 4'h0)
			if (k == 8)
			begin
				sse_spi_host_inst.send(0, 32'h3C000000, 32'hA5007FFF);
				repeat (30) @(negedge REF_CLK);
				`CHK(arm, 4'h0)
			end
			@(posedge REF_CLK);
			COMPARE_COMPLETE_READ <= 1'b1;
			@(posedge REF_CLK);
			COMPARE_COMPLETE_READ <= 1'b0;
			@(negedge REF_CLK);
			`CHK(COMPARE_COMPLETE_FLAGS_REG, 16'h0000)
		end
		$display("test frames done");
		STATE_SAFING <= 1'b0;
		sse_spi_host_inst.send(0, 32'h3C000000, 32'hA5007FFF);
		repeat (40) @(negedge REF_CLK);
		`CHK({COMPARE_COMPLETE_FLAGS_REG, arm}, 20'h00000)
		@(posedge REF_CLK);
		SAFING_STATE_MACHINE_RESET <= 1'b1;
		@(posedge REF_CLK);
		SAFING_STATE_MACHINE_RESET <= 1'b0;
		@(negedge REF_CLK);
		`CHK(RECORD_ENABLED, 16'h0000)
		$display("test state and clear done");
		final_report;
	end
endmodule
`default_nettype wire
